// File: design/uesfr_pkg.sv
// uesfr_pkg: constants shared by the endpoint status and fifo reset block.
// assumes a 32-bit AHB-Lite bus where each register is one aligned word.
package uesfr_pkg;

  localparam int unsigned EP_COUNT = 4;

  // word indices; byte address is four times the index
  localparam logic [9:0] STATUS_INDEX = 10'h000;
  localparam logic [9:0] SELECT_INDEX = 10'h001;
  localparam logic [9:0] IRQ_ENABLE_INDEX = 10'h0c2;
  localparam logic [9:0] FIFO_RESET_INDEX = 10'h0d5;
  localparam logic [9:0] IRQ_FLAGS_INDEX = 10'h0f8;

  // endpoint_status_control field positions
  localparam int unsigned DIR_BIT = 7;
  localparam int unsigned RSVD_BIT = 6;
  localparam int unsigned STALL_BIT = 5;
  localparam int unsigned TRANSMIT_READY_BIT = 4;
  localparam int unsigned STALL_SENT_OR_CRC_ERROR_BIT = 3;
  localparam int unsigned SETUP_BIT = 2;
  localparam int unsigned OUT_BIT = 1;
  localparam int unsigned IN_COMPLETE_BIT = 0;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] FIFO_RESET_RESET = 4'h0;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [1:0] SELECT_RESET = 2'h0;

  localparam logic [1:0] EP_TYPE_CONTROL = 2'h0;
  localparam logic [1:0] EP_TYPE_ISO = 2'h1;

  localparam logic [1:0] TOKEN_OUT = 2'h0;
  localparam logic [1:0] TOKEN_IN = 2'h1;
  localparam logic [1:0] TOKEN_SETUP = 2'h2;

  localparam logic [1:0] REPLY_ACK = 2'h0;
  localparam logic [1:0] REPLY_NAK = 2'h1;
  localparam logic [1:0] REPLY_STALL = 2'h2;
  localparam logic [1:0] REPLY_DATA = 2'h3;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h1,
    PH_WRITE = 3'h2,
    PH_READ = 3'h4
  } uesfr_phase_type;

endpackage

// File: design/uesfr_ep_status.sv
// uesfr_ep_status: status and control byte of one endpoint.
// assumes link events are one-cycle pulses already steered to this endpoint.
`timescale 1ns/1ns
module uesfr_ep_status (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [1:0] ep_type,
  input wire logic fw_write,
  input wire logic [7:0] fw_data,
  input wire logic ev_setup,
  input wire logic ev_out,
  input wire logic ev_crc_err,
  input wire logic ev_in_sent,
  input wire logic ev_in_ack,
  input wire logic ev_stall_sent,
  output logic [7:0] status,
  output logic status_event
);
  logic is_iso;
  logic dir;
  logic stall_rq;
  logic tx_ready;
  logic stl_crc;
  logic setup_rx;
  logic out_rx;
  logic in_cmp;
  logic set_stl_crc;
  logic set_in_cmp;

  assign is_iso = ep_type == uesfr_pkg::EP_TYPE_ISO;
  assign set_stl_crc = is_iso ? ev_crc_err : ev_stall_sent; // R09 R10
  assign set_in_cmp = is_iso ? ev_in_sent : ev_in_ack; // R16
  assign status_event = ev_setup | ev_out | set_stl_crc | set_in_cmp;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      dir <= 1'h0; // R18
      stall_rq <= 1'h0;
      tx_ready <= 1'h0;
    end
    else if (ev_setup)
    begin
      dir <= 1'h0; // R11
      stall_rq <= 1'h0;
      tx_ready <= 1'h0;
    end
    else if (fw_write)
    begin
      dir <= fw_data[uesfr_pkg::DIR_BIT]; // R01
      stall_rq <= fw_data[uesfr_pkg::STALL_BIT]; // R05
      tx_ready <= fw_data[uesfr_pkg::TRANSMIT_READY_BIT]; // R07
    end
    else if (is_iso ? ev_in_sent : ev_in_ack)
    begin
      tx_ready <= 1'h0; // R08
    end
  end

  // hardware flags: a written zero clears, a written one is ignored, an event wins
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      stl_crc <= 1'h0;
      setup_rx <= 1'h0;
      out_rx <= 1'h0;
      in_cmp <= 1'h0;
    end
    else if (ev_setup)
    begin
      stl_crc <= 1'h0; // R09
      setup_rx <= 1'h1; // R11
      out_rx <= 1'h0;
      in_cmp <= 1'h0;
    end
    else
    begin
      stl_crc <= set_stl_crc
        | (stl_crc & ~(fw_write & ~fw_data[uesfr_pkg::STALL_SENT_OR_CRC_ERROR_BIT])
        & ~(is_iso & ev_out)); // R10 R23
      setup_rx <= setup_rx & ~(fw_write & ~fw_data[uesfr_pkg::SETUP_BIT]); // R23
      out_rx <= ev_out | (out_rx & ~(fw_write & ~fw_data[uesfr_pkg::OUT_BIT])); // R13
      in_cmp <= set_in_cmp | (in_cmp & ~(fw_write & ~fw_data[uesfr_pkg::IN_COMPLETE_BIT])); // R16
    end
  end

  always_comb
  begin
    status = uesfr_pkg::STATUS_RESET;
    status[uesfr_pkg::DIR_BIT] = dir;
    status[uesfr_pkg::RSVD_BIT] = 1'h0; // R04
    status[uesfr_pkg::STALL_BIT] = stall_rq;
    status[uesfr_pkg::TRANSMIT_READY_BIT] = tx_ready;
    status[uesfr_pkg::STALL_SENT_OR_CRC_ERROR_BIT] = stl_crc;
    status[uesfr_pkg::SETUP_BIT] = setup_rx;
    status[uesfr_pkg::OUT_BIT] = out_rx;
    status[uesfr_pkg::IN_COMPLETE_BIT] = in_cmp;
  end
endmodule // uesfr_ep_status

// File: design/uesfr_handshake.sv
// uesfr_handshake: picks the answer to a host token from endpoint state.
// assumes the token and the addressed endpoint's bits arrive in one cycle.
`timescale 1ns/1ns
module uesfr_handshake (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic token_valid,
  input wire logic [1:0] token_kind,
  input wire logic stall_rq,
  input wire logic out_rx,
  input wire logic tx_ready,
  output logic reply_valid,
  output logic [1:0] reply_code
);
  logic [1:0] next_reply_code;

  always_comb
  begin
    next_reply_code = uesfr_pkg::REPLY_ACK;
    // setup is always taken, even over a pending out packet
    if (token_kind == uesfr_pkg::TOKEN_SETUP)
      next_reply_code = uesfr_pkg::REPLY_ACK; // R14
    else if (stall_rq)
      next_reply_code = uesfr_pkg::REPLY_STALL; // R05
    else if (token_kind == uesfr_pkg::TOKEN_OUT)
      next_reply_code = out_rx ? uesfr_pkg::REPLY_NAK : uesfr_pkg::REPLY_ACK; // R13
    else if (token_kind == uesfr_pkg::TOKEN_IN)
      next_reply_code = tx_ready ? uesfr_pkg::REPLY_DATA : uesfr_pkg::REPLY_NAK; // R07
    else
      next_reply_code = uesfr_pkg::REPLY_NAK;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      reply_valid <= 1'h0;
      reply_code <= uesfr_pkg::REPLY_ACK;
    end
    else
    begin
      reply_valid <= token_valid;
      if (token_valid)
        reply_code <= next_reply_code;
    end
  end
endmodule // uesfr_handshake

// File: design/uesfr_top.sv
// uesfr_top: endpoint status/control, endpoint interrupt flags and fifo resets.
// assumes an AHB-Lite master for firmware and a serial engine that reports
// link events as one-cycle pulses tagged with the endpoint number.
//
// Function
// (R01) direction bit matters only on control endpoints
// (R02) firmware programs direction first after setup
// (R03) firmware clears direction at control-out status
// (R04) bit six reads zero, never written one
// (R05) stall request makes next handshake a stall
// (R06) firmware sets transmit-ready after loading packet
// (R07) transmit-ready on empty fifo sends zero-length
// (R08) transmit-ready cleared on sent or acknowledged
// (R09) stall-sent flag set, cleared by setup
// (R10) isochronous crc flag, cleared by good data
// (R11) setup sets flag, clears all other bits
// (R12) firmware clears setup flag after reading bytes
// (R13) out flag set; further outs get nak
// (R14) early setup may overwrite fifo on control
// (R15) firmware clears out flag after reading data
// (R16) in-complete set when sent or acknowledged
// (R17) firmware clears in-complete before next packet
// (R18) status and fifo reset registers reset zero
// (R19) fifo reset bits reset endpoint fifos
// (R20) fifo reset upper bits read zero
// (R21) status register follows selected endpoint number
// (R22) enabled status events set interrupt flags
// (R23) hardware flags cleared by writing zero
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ns
module uesfr_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] ep_types,
  input wire logic [1:0] link_ep,
  input wire logic link_token_valid,
  input wire logic [1:0] link_token_kind,
  input wire logic link_setup_ok,
  input wire logic link_out_ok,
  input wire logic link_crc_err,
  input wire logic link_in_sent,
  input wire logic link_in_ack,
  input wire logic link_stall_sent,
  output logic reply_valid,
  output logic [1:0] reply_code,
  output logic [3:0] fifo_reset,
  output logic [3:0] ctrl_in_stage
);
  uesfr_pkg::uesfr_phase_type phase;
  logic [9:0] addr_index;
  logic accept;
  logic data_write;
  logic [7:0] wdata8;
  logic [1:0] endpoint_select;
  logic [3:0] endpoint_irq_enable;
  logic [3:0] endpoint_irq_flags;
  logic [7:0] ep_status [uesfr_pkg::EP_COUNT];
  logic [3:0] ep_event;
  logic [3:0] ep_ctrl_dir;
  logic [7:0] read_value;
  logic [7:0] link_status;
  logic status_write;

  // bus slave: zero wait states, every transfer answered OKAY
  assign accept = hsel & hready & htrans[1];
  assign data_write = phase == uesfr_pkg::PH_WRITE;
  assign wdata8 = hwdata[7:0];
  assign status_write = data_write && addr_index == uesfr_pkg::STATUS_INDEX;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      phase <= uesfr_pkg::PH_IDLE;
    else if (hready)
    begin
      if (accept)
        phase <= hwrite ? uesfr_pkg::PH_WRITE : uesfr_pkg::PH_READ;
      else
        phase <= uesfr_pkg::PH_IDLE;
    end
  end

  // only the word index is decoded; upper address bits alias
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      addr_index <= 10'h000;
    else if (accept)
      addr_index <= haddr[11:2];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      hreadyout <= 1'h0;
      hresp <= 1'h0;
    end
    else
    begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end
  end

  // read data is captured at the address phase so it can leave a flop
  always_comb
  begin
    case (haddr[11:2])
      uesfr_pkg::STATUS_INDEX: read_value = ep_status[endpoint_select]; // R21
      uesfr_pkg::SELECT_INDEX: read_value = {6'h00, endpoint_select};
      uesfr_pkg::IRQ_ENABLE_INDEX: read_value = {4'h0, endpoint_irq_enable};
      uesfr_pkg::FIFO_RESET_INDEX: read_value = {4'h0, fifo_reset}; // R20
      uesfr_pkg::IRQ_FLAGS_INDEX: read_value = {4'h0, endpoint_irq_flags};
      default: read_value = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      hrdata <= 32'h0000_0000;
    else if (accept && !hwrite)
      hrdata <= {24'h00_0000, read_value};
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      endpoint_select <= uesfr_pkg::SELECT_RESET;
    else if (data_write && addr_index == uesfr_pkg::SELECT_INDEX)
      endpoint_select <= wdata8[1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      endpoint_irq_enable <= uesfr_pkg::IRQ_RESET;
    else if (data_write && addr_index == uesfr_pkg::IRQ_ENABLE_INDEX)
      endpoint_irq_enable <= wdata8[3:0];
  end

  // upper bits are not stored, so they always read zero
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      fifo_reset <= uesfr_pkg::FIFO_RESET_RESET; // R18
    else if (data_write && addr_index == uesfr_pkg::FIFO_RESET_INDEX)
      fifo_reset <= wdata8[3:0]; // R19 R20
  end

  // flag is raised by an enabled event, dropped only by a written zero;
  // an event in the clearing cycle keeps the flag set
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      endpoint_irq_flags <= uesfr_pkg::IRQ_RESET;
    else if (data_write && addr_index == uesfr_pkg::IRQ_FLAGS_INDEX)
      endpoint_irq_flags <= (endpoint_irq_flags & wdata8[3:0])
        | (ep_event & endpoint_irq_enable); // R22
    else
      endpoint_irq_flags <= endpoint_irq_flags | (ep_event & endpoint_irq_enable); // R22
  end

  // one status byte per endpoint, steered by the link's endpoint number
  genvar g;
  generate
    for (g = 0; g < uesfr_pkg::EP_COUNT; g++)
    begin : g_ep
      logic hit;
      logic sel;
      assign hit = link_ep == 2'(g);
      assign sel = endpoint_select == 2'(g);
      assign ep_ctrl_dir[g] = ep_status[g][uesfr_pkg::DIR_BIT]
        && ep_types[2*g +: 2] == uesfr_pkg::EP_TYPE_CONTROL; // R01
      uesfr_ep_status u_status (
        .sys_clk(sys_clk),
        .srst(srst),
        .ep_type(ep_types[2*g +: 2]),
        .fw_write(status_write && sel), // R21
        .fw_data(wdata8),
        .ev_setup(link_setup_ok && hit),
        .ev_out(link_out_ok && hit),
        .ev_crc_err(link_crc_err && hit),
        .ev_in_sent(link_in_sent && hit),
        .ev_in_ack(link_in_ack && hit),
        .ev_stall_sent(link_stall_sent && hit),
        .status(ep_status[g]),
        .status_event(ep_event[g])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ctrl_in_stage <= 4'h0;
    else
      ctrl_in_stage <= ep_ctrl_dir;
  end

  assign link_status = ep_status[link_ep];

  uesfr_handshake u_handshake (
    .sys_clk(sys_clk),
    .srst(srst),
    .token_valid(link_token_valid),
    .token_kind(link_token_kind),
    .stall_rq(link_status[uesfr_pkg::STALL_BIT]), // R05
    .out_rx(link_status[uesfr_pkg::OUT_BIT]), // R13
    .tx_ready(link_status[uesfr_pkg::TRANSMIT_READY_BIT]),
    .reply_valid(reply_valid),
    .reply_code(reply_code)
  );
endmodule // uesfr_top

// File: test/uesfr_host_model.sv
// uesfr_host_model: usb host seen as link pulses and tokens.
// assumes calls start just after a rising edge of sys_clk.
`timescale 1ns/1ns
module uesfr_host_model (
  input wire logic sys_clk,
  input wire logic reply_valid,
  input wire logic [1:0] reply_code,
  output logic [1:0] link_ep,
  output logic link_token_valid,
  output logic [1:0] link_token_kind,
  output logic link_setup_ok,
  output logic link_out_ok,
  output logic link_crc_err,
  output logic link_in_sent,
  output logic link_in_ack,
  output logic link_stall_sent
);
  logic [5:0] ev = '0;
  logic [1:0] got;
  logic rv;
  assign {link_setup_ok, link_out_ok, link_crc_err} = ev[5:3];
  assign {link_in_sent, link_in_ack, link_stall_sent} = ev[2:0];
  initial
  begin
    link_ep = '0;
    link_token_valid = '0;
    link_token_kind = '0;
  end
  task pulse(input logic [5:0] m);
    ev <= m;
    @(posedge sys_clk);
    ev <= '0;
  endtask
  // the host follows up only on what the reply allowed
  task xfer(input logic [1:0] ep, k, input logic iso);
    link_ep <= ep;
    link_token_kind <= k;
    link_token_valid <= 1'h1;
    @(posedge sys_clk);
    link_token_valid <= 1'h0;
    #1;
    rv = reply_valid;
    got = reply_code;
    @(posedge sys_clk);
    if (got == uesfr_pkg::REPLY_STALL)
      pulse(6'h01);
    else if (got == uesfr_pkg::REPLY_DATA)
      pulse(iso ? 6'h04 : 6'h02);
    else if (got == uesfr_pkg::REPLY_ACK)
      pulse(k == uesfr_pkg::TOKEN_SETUP ? 6'h20 : 6'h10);
  endtask
endmodule // uesfr_host_model

// File: test/uesfr_top_chk.sv
// uesfr_top_chk: port-level properties of the endpoint status block.
// assumes it is bound to uesfr_top and sees only its ports.
`timescale 1ns/1ns
module uesfr_top_chk (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] ep_types,
  input wire logic link_token_valid,
  input wire logic [1:0] link_token_kind,
  input wire logic reply_valid,
  input wire logic [1:0] reply_code,
  input wire logic [3:0] fifo_reset,
  input wire logic [3:0] ctrl_in_stage
);
  logic fr_wr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  always_ff @(posedge sys_clk)
    fr_wr <= !srst && hsel && hready && htrans[1] && hwrite
      && haddr[11:2] == uesfr_pkg::FIFO_RESET_INDEX;
  reply_timing_a:
    assert property (link_token_valid |=> reply_valid) else $error("late reply");
  reply_cause_a:
    assert property (reply_valid |-> $past(link_token_valid)) else $error("stray reply");
  setup_ack_a:
    assert property (link_token_valid && link_token_kind == uesfr_pkg::TOKEN_SETUP
      |=> reply_code == uesfr_pkg::REPLY_ACK) else $error("setup not acked");
  code_hold_a:
    assert property (!link_token_valid |=> $stable(reply_code)) else $error("code moved");
  fifo_follow_a:
    assert property (fr_wr |=> fifo_reset == $past(hwdata[3:0])) else $error("fifo reset");
  ctrl_stage_a:
    assert property (ctrl_in_stage[0] |-> $past(ep_types[1:0]) == uesfr_pkg::EP_TYPE_CONTROL)
      else $error("dir on non-control");
  read_zero_a:
    assert property (hrdata[31:8] == 24'h0 && !hrdata[6]) else $error("reserved bits");
  bus_ok_a:
    assert property (!$past(srst) |-> hreadyout && !hresp) else $error("bus not ready");
endmodule // uesfr_top_chk
bind uesfr_top uesfr_top_chk u_chk (
  .sys_clk(sys_clk),
  .srst(srst),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .ep_types(ep_types),
  .link_token_valid(link_token_valid),
  .link_token_kind(link_token_kind),
  .reply_valid(reply_valid),
  .reply_code(reply_code),
  .fifo_reset(fifo_reset),
  .ctrl_in_stage(ctrl_in_stage)
);

// File: test/uesfr_top_tb.sv
// uesfr_top_tb: firmware over AHB-Lite, host model on the link side.
// assumes ep0 control, ep1 isochronous, ep2 and ep3 bulk.
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module uesfr_top_tb;
  logic sys_clk = '0;
  logic srst = 1'h1;
  logic hsel = '0;
  logic hwrite = '0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] ep_types = 8'he4;
  logic hready, hreadyout, hresp, reply_valid, link_token_valid;
  logic link_setup_ok, link_out_ok, link_crc_err, link_in_sent, link_in_ack;
  logic link_stall_sent;
  logic [31:0] hrdata;
  logic [1:0] link_ep, link_token_kind, reply_code;
  logic [3:0] fifo_reset, ctrl_in_stage;
  int n_mismatch = 0;
  int compares = 0;
  localparam logic [9:0] a_st = uesfr_pkg::STATUS_INDEX;
  localparam logic [9:0] a_sel = uesfr_pkg::SELECT_INDEX;
  localparam logic [9:0] a_ie = uesfr_pkg::IRQ_ENABLE_INDEX;
  localparam logic [9:0] a_fr = uesfr_pkg::FIFO_RESET_INDEX;
  localparam logic [9:0] a_if = uesfr_pkg::IRQ_FLAGS_INDEX;
  assign hready = hreadyout;
  always #4 sys_clk = ~sys_clk;
  uesfr_top u_dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .ep_types(ep_types),
    .link_ep(link_ep),
    .link_token_valid(link_token_valid),
    .link_token_kind(link_token_kind),
    .link_setup_ok(link_setup_ok),
    .link_out_ok(link_out_ok),
    .link_crc_err(link_crc_err),
    .link_in_sent(link_in_sent),
    .link_in_ack(link_in_ack),
    .link_stall_sent(link_stall_sent),
    .reply_valid(reply_valid),
    .reply_code(reply_code),
    .fifo_reset(fifo_reset),
    .ctrl_in_stage(ctrl_in_stage)
  );
  uesfr_host_model u_host (
    .sys_clk(sys_clk),
    .reply_valid(reply_valid),
    .reply_code(reply_code),
    .link_ep(link_ep),
    .link_token_valid(link_token_valid),
    .link_token_kind(link_token_kind),
    .link_setup_ok(link_setup_ok),
    .link_out_ok(link_out_ok),
    .link_crc_err(link_crc_err),
    .link_in_sent(link_in_sent),
    .link_in_ack(link_in_ack),
    .link_stall_sent(link_stall_sent)
  );
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one bus phase; a stuck hready ends the run
  task step;
    int i;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
    end
    while (hreadyout !== 1'h1 && i < 50);
    if (hreadyout !== 1'h1)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask
  task wr(input logic [9:0] ix, input logic [7:0] v);
    hsel <= 1'h1;
    haddr <= {20'h0, ix, 2'h0};
    htrans <= 2'h2;
    hwrite <= 1'h1;
    step;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    step;
  endtask
  task rd(input logic [9:0] ix, input logic [7:0] e);
    hsel <= 1'h1;
    haddr <= {20'h0, ix, 2'h0};
    htrans <= 2'h2;
    hwrite <= 1'h0;
    step;
    hsel <= 1'h0;
    htrans <= 2'h0;
    step;
    `CHK(hrdata[7:0], e)
  endtask
  task tok(input logic [1:0] ep, k, input logic iso, input logic [1:0] e);
    u_host.xfer(ep, k, iso);
    `CHK({u_host.rv, u_host.got}, {1'h1, e})
  endtask
  task t_reset;
    rd(a_st, 8'h00);
    rd(a_fr, 8'h00);
    wr(10'h3ff, 8'hff);
    rd(10'h3ff, 8'h00);
    $display("test reset done");
  endtask
  task t_fifo;
    wr(a_fr, 8'hff);
    rd(a_fr, 8'h0f);
    `CHK(fifo_reset, 4'hf)
    wr(a_fr, 8'h00);
    rd(a_fr, 8'h00);
    `CHK(fifo_reset, 4'h0)
    $display("test fifo reset done");
  endtask
  task t_ctrl;
    wr(a_sel, 8'h00);
    wr(a_st, 8'hf0);
    rd(a_st, 8'hb0);
    tok(2'h0, uesfr_pkg::TOKEN_IN, 1'h0, uesfr_pkg::REPLY_STALL);
    rd(a_st, 8'hb8);
    tok(2'h0, uesfr_pkg::TOKEN_SETUP, 1'h0, uesfr_pkg::REPLY_ACK);
    rd(a_st, 8'h04);
    wr(a_st, 8'h84);
    repeat (2) @(posedge sys_clk);
    `CHK(ctrl_in_stage, 4'h1)
    wr(a_st, 8'h00);
    rd(a_st, 8'h00);
    $display("test control done");
  endtask
  task t_bulk;
    wr(a_ie, 8'h04);
    wr(a_sel, 8'h02);
    tok(2'h2, uesfr_pkg::TOKEN_OUT, 1'h0, uesfr_pkg::REPLY_ACK);
    rd(a_st, 8'h02);
    rd(a_if, 8'h04);
    tok(2'h2, uesfr_pkg::TOKEN_OUT, 1'h0, uesfr_pkg::REPLY_NAK);
    wr(a_st, 8'h03);
    rd(a_st, 8'h02);
    wr(a_st, 8'h00);
    wr(a_if, 8'h00);
    rd(a_if, 8'h00);
    wr(a_st, 8'h90);
    repeat (2) @(posedge sys_clk);
    `CHK(ctrl_in_stage, 4'h0)
    tok(2'h2, uesfr_pkg::TOKEN_IN, 1'h0, uesfr_pkg::REPLY_DATA);
    rd(a_st, 8'h81);
    tok(2'h2, uesfr_pkg::TOKEN_IN, 1'h0, uesfr_pkg::REPLY_NAK);
    wr(a_st, 8'h00);
    rd(a_if, 8'h04);
    $display("test bulk done");
  endtask
  task t_iso;
    wr(a_sel, 8'h01);
    wr(a_st, 8'h10);
    tok(2'h1, uesfr_pkg::TOKEN_IN, 1'h1, uesfr_pkg::REPLY_DATA);
    rd(a_st, 8'h01);
    u_host.pulse(6'h08);
    rd(a_st, 8'h09);
    tok(2'h1, uesfr_pkg::TOKEN_OUT, 1'h1, uesfr_pkg::REPLY_ACK);
    rd(a_st, 8'h03);
    wr(a_sel, 8'h00);
    rd(a_st, 8'h00);
    $display("test iso done");
  endtask
  // state is left non-zero on purpose so the second reset has work to do
  task t_mid_reset;
    tok(2'h0, uesfr_pkg::TOKEN_OUT, 1'h0, uesfr_pkg::REPLY_ACK);
    tok(2'h0, uesfr_pkg::TOKEN_SETUP, 1'h0, uesfr_pkg::REPLY_ACK);
    rd(a_st, 8'h04);
    wr(a_st, 8'hb4);
    wr(a_fr, 8'h0a);
    srst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    `CHK(fifo_reset, 4'h0)
    `CHK(ctrl_in_stage, 4'h0)
    rd(a_st, 8'h00);
    rd(a_fr, 8'h00);
    $display("test mid reset done");
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    t_reset;
    t_fifo;
    t_ctrl;
    t_bulk;
    t_iso;
    t_mid_reset;
    tally_and_finish;
  end
endmodule // uesfr_top_tb
